/* logic/ssp_pkg.sv */
// Constants and types shared by the shutoff and parameter-set selection block
package ssp_pkg;

  localparam int SSP_NUM_TERMS = 12;

  // APB register byte offsets
  localparam logic [7:0] SSP_ADDR_POLARITY = 8'h00;
  localparam logic [7:0] SSP_ADDR_VALIDITY = 8'h04;
  localparam logic [7:0] SSP_ADDR_COMM = 8'h08;
  localparam logic [7:0] SSP_ADDR_STATUS = 8'h0c;
  localparam logic [7:0] SSP_ADDR_ASSIGN_BASE = 8'h10;
  localparam logic [7:0] SSP_ADDR_ASSIGN_LAST = 8'h3c;

  // Field positions
  localparam int SSP_COMM_REQ_BIT = 0;
  localparam int SSP_SEQ_REQ_BIT = 1;
  localparam int SSP_ST_ENABLE_BIT = 0;
  localparam int SSP_ST_SET_LSB = 1;
  localparam int SSP_ST_TWO_SET_BIT = 3;
  localparam int SSP_ST_SHUT_TERM_BIT = 4;
  localparam int SSP_ST_SECOND_BIT = 5;
  localparam int SSP_ST_THIRD_BIT = 6;
  localparam int SSP_ST_RUNNING_BIT = 7;

  // Terminal function assignment codes
  localparam logic [7:0] SSP_CODE_SECOND = 8'h03;
  localparam logic [7:0] SSP_CODE_THIRD = 8'h09;
  localparam logic [7:0] SSP_CODE_SHUTOFF = 8'h18;
  localparam logic [7:0] SSP_CODE_NONE = 8'hff;

  // Polarity selection values
  localparam logic [7:0] SSP_POL_OPEN = 8'h00;
  localparam logic [7:0] SSP_POL_CLOSED = 8'h02;
  localparam logic [7:0] SSP_POL_MIXED = 8'h04;

  // Validity condition values
  localparam logic [7:0] SSP_VALID_IMMEDIATE = 8'h00;
  localparam logic [7:0] SSP_VALID_CONST_SPEED = 8'h0a;

  // Parameter set encodings
  localparam logic [1:0] SSP_SET_FIRST = 2'h0;
  localparam logic [1:0] SSP_SET_SECOND = 2'h1;
  localparam logic [1:0] SSP_SET_THIRD = 2'h2;

  // Reset values
  localparam logic [7:0] SSP_POLARITY_RST = 8'h00;
  localparam logic [7:0] SSP_VALIDITY_RST = 8'h00;
  // Terminal 0 is the dedicated shutoff terminal, terminal 1 the dedicated second-set terminal
  localparam logic [SSP_NUM_TERMS-1:0][7:0] SSP_CODES_RST =
    {{(SSP_NUM_TERMS-2){SSP_CODE_NONE}}, SSP_CODE_SECOND, SSP_CODE_SHUTOFF};

  typedef struct packed {
    logic [SSP_NUM_TERMS-1:0] sync1;
    logic [SSP_NUM_TERMS-1:0] sync2;
    logic [7:0] polarity;
    logic [7:0] validity;
    logic comm_req;
    logic seq_req;
    logic [SSP_NUM_TERMS-1:0][7:0] codes;
    logic [1:0] pend3;
    logic pend2;
    logic [1:0] active3;
    logic active2;
    logic out_en;
    logic [31:0] prdata;
  } ssp_state_type;

endpackage

/* logic/ssp_term_if.sv */
// Carrier between the top module and the terminal function decoder
`timescale 1ns/100ps
interface ssp_term_if;
  import ssp_pkg::*;
  logic [SSP_NUM_TERMS-1:0] level;
  logic [SSP_NUM_TERMS-1:0][7:0] codes;
  logic shutoff;
  logic second;
  logic third;
  modport host (output level, output codes, input shutoff, input second, input third);
  modport map (input level, input codes, output shutoff, output second, output third);
endinterface

/* logic/ssp_term_map.sv */
// Routes synchronised terminal levels to functions by assignment code
`timescale 1ns/100ps
module ssp_term_map (
  ssp_term_if.map bus
);
  import ssp_pkg::*;

  always_comb begin
    bus.shutoff = 1'b0;
    bus.second = 1'b0;
    bus.third = 1'b0;
    for (int i = 0; i < SSP_NUM_TERMS; i++) begin
      // Several terminals with one code are ORed together
      if (bus.codes[i] == SSP_CODE_SHUTOFF) begin
        bus.shutoff = bus.shutoff | bus.level[i];
      end
      if (bus.codes[i] == SSP_CODE_SECOND) begin
        bus.second = bus.second | bus.level[i];
      end
      if (bus.codes[i] == SSP_CODE_THIRD) begin
        bus.third = bus.third | bus.level[i];
      end
    end
  end

endmodule

/* logic/ssp_shutoff_set_select.sv */
// Output shutoff decision and parameter-set selection with APB registers
`timescale 1ns/100ps
module ssp_shutoff_set_select (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [ssp_pkg::SSP_NUM_TERMS-1:0] terminal_in,
  input wire logic drive_running,
  input wire logic drive_const_speed,
  output logic output_enable,
  output logic [1:0] active_set,
  output logic active_two_set
);
  import ssp_pkg::*;

  ssp_state_type s_q;
  ssp_state_type s_d;
  ssp_term_if term_bus ();

  logic setup_phase;
  logic access_phase;
  logic wr_access;
  logic in_assign;
  logic addr_hit;
  logic [3:0] assign_idx;
  logic [5:0] word_addr;
  logic [31:0] rd_word;
  logic shut_term;
  logic comm_any;
  logic enable_calc;
  logic speed_gate;
  logic [1:0] want3;

  // Decoder sees only the second synchroniser stage
  assign term_bus.level = s_q.sync2;
  assign term_bus.codes = s_q.codes;

  ssp_term_map u_map (
    .bus(term_bus.map)
  );

  assign shut_term = term_bus.shutoff;
  // Sequence program request joins the communication path
  assign comm_any = s_q.comm_req | s_q.seq_req;

  // APB decode
  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign wr_access = access_phase & pwrite & addr_hit;
  assign word_addr = paddr[7:2];
  assign in_assign = (paddr >= SSP_ADDR_ASSIGN_BASE) && (paddr <= SSP_ADDR_ASSIGN_LAST);
  assign assign_idx = 4'(word_addr - SSP_ADDR_ASSIGN_BASE[7:2]);
  always_comb begin
    addr_hit = 1'b0;
    if (paddr[1:0] == 2'h0) begin
      addr_hit = (paddr == SSP_ADDR_POLARITY) || (paddr == SSP_ADDR_VALIDITY) ||
                 (paddr == SSP_ADDR_COMM) || (paddr == SSP_ADDR_STATUS) || in_assign;
    end
  end

  // No wait states; read data was captured during setup
  assign pready = access_phase;
  assign pslverr = access_phase & ~addr_hit;
  assign prdata = s_q.prdata;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (addr_hit) begin
      if (paddr == SSP_ADDR_POLARITY) begin
        rd_word[7:0] = s_q.polarity;
      end else if (paddr == SSP_ADDR_VALIDITY) begin
        rd_word[7:0] = s_q.validity;
      end else if (paddr == SSP_ADDR_COMM) begin
        rd_word[SSP_COMM_REQ_BIT] = s_q.comm_req;
        rd_word[SSP_SEQ_REQ_BIT] = s_q.seq_req;
      end else if (paddr == SSP_ADDR_STATUS) begin
        rd_word[SSP_ST_ENABLE_BIT] = s_q.out_en;
        rd_word[SSP_ST_SET_LSB +: 2] = s_q.active3;
        rd_word[SSP_ST_TWO_SET_BIT] = s_q.active2;
        rd_word[SSP_ST_SHUT_TERM_BIT] = shut_term;
        rd_word[SSP_ST_SECOND_BIT] = term_bus.second;
        rd_word[SSP_ST_THIRD_BIT] = term_bus.third;
        rd_word[SSP_ST_RUNNING_BIT] = drive_running;
      end else begin
        rd_word[7:0] = s_q.codes[assign_idx];
      end
    end
  end

  // Shutoff decision; no operation mode input can mask the terminal
  always_comb begin
    unique case (s_q.polarity)
      SSP_POL_CLOSED: begin
        // Sequence request stays normally open even with a closed contact
        enable_calc = shut_term & s_q.comm_req & ~s_q.seq_req;
      end
      SSP_POL_MIXED: begin
        enable_calc = shut_term & ~comm_any;
      end
      default: begin
        // Unlisted settings fall back to normally open
        enable_calc = ~shut_term & ~comm_any;
      end
    endcase
  end

  // Third select outranks second
  always_comb begin
    if (term_bus.third) begin
      want3 = SSP_SET_THIRD;
    end else if (term_bus.second) begin
      want3 = SSP_SET_SECOND;
    end else begin
      want3 = SSP_SET_FIRST;
    end
  end

  // Other validity settings behave like the immediate one
  assign speed_gate = (s_q.validity == SSP_VALID_CONST_SPEED) && !drive_const_speed;

  always_comb begin
    s_d = s_q;
    s_d.sync1 = terminal_in;
    s_d.sync2 = s_q.sync1;
    if (wr_access) begin
      if (paddr == SSP_ADDR_POLARITY) begin
        s_d.polarity = pwdata[7:0];
      end else if (paddr == SSP_ADDR_VALIDITY) begin
        s_d.validity = pwdata[7:0];
      end else if (paddr == SSP_ADDR_COMM) begin
        // Held until software writes it again
        s_d.comm_req = pwdata[SSP_COMM_REQ_BIT];
        s_d.seq_req = pwdata[SSP_SEQ_REQ_BIT];
      end else if (in_assign) begin
        s_d.codes[assign_idx] = pwdata[7:0];
      end
    end
    // Selection is frozen while running, so only the constant-speed gate can change the active set mid-motion
    if (!drive_running) begin
      s_d.pend3 = want3;
      s_d.pend2 = term_bus.second;
    end
    s_d.active3 = speed_gate ? SSP_SET_FIRST : s_q.pend3;
    s_d.active2 = speed_gate ? 1'b0 : s_q.pend2;
    // No ramp here: a shutoff drops enable on the next edge and the motor coasts
    s_d.out_en = enable_calc;
    if (setup_phase) begin
      s_d.prdata = rd_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{sync1: '0, sync2: '0, polarity: SSP_POLARITY_RST, validity: SSP_VALIDITY_RST,
               comm_req: 1'b0, seq_req: 1'b0, codes: SSP_CODES_RST, pend3: SSP_SET_FIRST,
               pend2: 1'b0, active3: SSP_SET_FIRST, active2: 1'b0, out_en: 1'b0,
               prdata: 32'h0000_0000};
    end else begin
      s_q <= s_d;
    end
  end

  assign output_enable = s_q.out_en;
  assign active_set = s_q.active3;
  assign active_two_set = s_q.active2;

  // Shutoff decision, one edge after the inputs are seen
  a_pol_mixed_enable: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.polarity == SSP_POL_MIXED && shut_term && !comm_any) |=> s_q.out_en)
    else $error("Mixed polarity enable mismatch");

  a_mixed_term_off: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.polarity == SSP_POL_MIXED && !shut_term) |=> !s_q.out_en)
    else $error("Mixed polarity open terminal kept output");

  a_mixed_comm_on: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.polarity == SSP_POL_MIXED && s_q.comm_req) |=> !s_q.out_en)
    else $error("Mixed polarity communication request kept output");

  a_pol_open_enable: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.polarity == SSP_POL_OPEN && !shut_term && !comm_any) |=> s_q.out_en)
    else $error("Normally open enable mismatch");

  a_open_term_on: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.polarity == SSP_POL_OPEN && shut_term) |=> !s_q.out_en)
    else $error("Normally open terminal request kept output");

  a_pol_closed_enable: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.polarity == SSP_POL_CLOSED && shut_term && s_q.comm_req && !s_q.seq_req) |=> s_q.out_en)
    else $error("Normally closed enable mismatch");

  a_closed_term_off: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.polarity == SSP_POL_CLOSED && !shut_term) |=> !s_q.out_en)
    else $error("Normally closed open terminal kept output");

  a_closed_comm_off: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.polarity == SSP_POL_CLOSED && !s_q.comm_req) |=> !s_q.out_en)
    else $error("Normally closed open communication kept output");

  a_seq_like_comm: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.seq_req |=> !s_q.out_en)
    else $error("Sequence shutoff did not cut output");

  a_cut_at_once: assert property (@(posedge pclk) disable iff (!presetn)
    !enable_calc |=> !s_q.out_en)
    else $error("Shutoff not applied on the next edge");

  // Terminal routing
  a_remap_shutoff: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.codes[5] == SSP_CODE_SHUTOFF && s_q.sync2[5]) |-> shut_term)
    else $error("Reassigned terminal not routed to shutoff");

  a_shut_or_terms: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.codes[6] == SSP_CODE_SHUTOFF && s_q.sync2[6]) |-> shut_term)
    else $error("Second shutoff terminal not ORed in");

  a_shut_dedicated: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.codes[0] == SSP_CODE_SHUTOFF && s_q.sync2[0]) |-> shut_term)
    else $error("Dedicated shutoff terminal not routed");

  a_default_shut_map: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.codes == SSP_CODES_RST) |-> (shut_term == s_q.sync2[0]))
    else $error("Default shutoff mapping wrong");

  a_default_second_map: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.codes == SSP_CODES_RST) |-> (term_bus.second == s_q.sync2[1]) && !term_bus.third)
    else $error("Default set select mapping wrong");

  a_third_routed: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.codes[7] == SSP_CODE_THIRD && s_q.sync2[7]) |-> term_bus.third)
    else $error("Third select terminal not routed");

  // Set selection
  a_third_priority: assert property (@(posedge pclk) disable iff (!presetn)
    (!drive_running && term_bus.third) |=> (s_q.pend3 == SSP_SET_THIRD))
    else $error("Third set not prioritised");

  a_second_pending: assert property (@(posedge pclk) disable iff (!presetn)
    (!drive_running && term_bus.second && !term_bus.third) |=> (s_q.pend3 == SSP_SET_SECOND))
    else $error("Second set not selected");

  a_first_pending: assert property (@(posedge pclk) disable iff (!presetn)
    (!drive_running && !term_bus.second && !term_bus.third) |=> (s_q.pend3 == SSP_SET_FIRST))
    else $error("First set not selected");

  a_hold_running: assert property (@(posedge pclk) disable iff (!presetn)
    drive_running |=> (s_q.pend3 == $past(s_q.pend3)) && (s_q.pend2 == $past(s_q.pend2)))
    else $error("Set changed while running");

  a_adopt_on_stop: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(drive_running) |=> (s_q.pend3 == $past(want3)))
    else $error("New set not adopted after stop");

  a_const_speed_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.validity == SSP_VALID_CONST_SPEED && !drive_const_speed) |=> (s_q.active3 == SSP_SET_FIRST))
    else $error("Set applied outside constant speed");

  a_const_speed_apply: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.validity == SSP_VALID_CONST_SPEED && drive_const_speed) |=> (s_q.active3 == $past(s_q.pend3)))
    else $error("Set not applied at constant speed");

  a_two_set_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.validity == SSP_VALID_CONST_SPEED && !drive_const_speed) |=> !s_q.active2)
    else $error("Two-set function applied outside constant speed");

  a_immediate_apply: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.validity == SSP_VALID_IMMEDIATE) |=> (s_q.active3 == $past(s_q.pend3)))
    else $error("Selected set not applied immediately");

  a_two_set_immediate: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.validity == SSP_VALID_IMMEDIATE) |=> (s_q.active2 == $past(s_q.pend2)))
    else $error("Two-set selection not applied immediately");

  a_two_set_follow: assert property (@(posedge pclk) disable iff (!presetn)
    !drive_running |=> (s_q.pend2 == $past(term_bus.second)))
    else $error("Two-set pending does not follow second select");

  a_two_set_select: assert property (@(posedge pclk) disable iff (!presetn)
    (!drive_running && term_bus.second && term_bus.third) |=> s_q.pend2 ##1 (s_q.active2 || $past(speed_gate)))
    else $error("Two-set function ignored second select");

  a_set_code_legal: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.active3 != 2'h3)
    else $error("Active set code out of range");

  // Register bus and stored bits
  a_comm_bit_held: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_access && paddr == SSP_ADDR_COMM) |=> (s_q.comm_req == $past(s_q.comm_req)))
    else $error("Communication request changed without a write");

  a_comm_bit_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && paddr == SSP_ADDR_COMM) |=> (s_q.comm_req == $past(pwdata[SSP_COMM_REQ_BIT])))
    else $error("Communication request write lost");

  a_seq_bit_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && paddr == SSP_ADDR_COMM) |=> (s_q.seq_req == $past(pwdata[SSP_SEQ_REQ_BIT])))
    else $error("Sequence request write lost");

  a_polarity_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && paddr == SSP_ADDR_POLARITY) |=> (s_q.polarity == $past(pwdata[7:0])))
    else $error("Polarity write lost");

  a_validity_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && paddr == SSP_ADDR_VALIDITY) |=> (s_q.validity == $past(pwdata[7:0])))
    else $error("Validity write lost");

  a_code_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && paddr == SSP_ADDR_ASSIGN_BASE + 8'h14) |=> (s_q.codes[5] == $past(pwdata[7:0])))
    else $error("Terminal code write lost");

  a_bad_write_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && !addr_hit) |=> (s_q.polarity == $past(s_q.polarity)) &&
      (s_q.validity == $past(s_q.validity)))
    else $error("Unmapped write changed a register");

  a_ready_no_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable) |-> pready)
    else $error("Access cycle without ready");

  a_misaligned_error: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && paddr[1:0] != 2'h0) |-> pslverr)
    else $error("Misaligned access without error");

  a_error_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && paddr[1:0] != 2'h0) |=> (prdata == 32'h0000_0000))
    else $error("Misaligned read returned data");

  a_read_capture: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && paddr == SSP_ADDR_POLARITY) |=> (prdata == {24'h00_0000, $past(s_q.polarity)}))
    else $error("Polarity read data not captured in setup");

endmodule

/* testbench/ssp_field_model.sv */
// Field wiring and drive run-state model feeding the block's terminal side
`timescale 1ns/100ps
module ssp_field_model (
  input wire logic pclk,
  input wire logic [11:0] want,
  input wire logic run_req,
  input wire logic const_req,
  output logic [11:0] terminal_in,
  output logic drive_running,
  output logic drive_const_speed
);
  // Wiring settles one clock after the bench asks for a level
  always @(posedge pclk) begin
    terminal_in <= want;
    drive_running <= run_req;
    drive_const_speed <= const_req;
  end
endmodule

/* testbench/ssp_shutoff_set_select_bench.sv */
// Self-checking bench for the shutoff decision and parameter-set selection
`timescale 1ns/100ps
module ssp_shutoff_set_select_bench;
  import ssp_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic pready, pslverr, e, output_enable, active_two_set, drive_running, drive_const_speed;
  logic [1:0] active_set;
  logic [11:0] tw = '0, terminal_in;
  logic run = 0, cs = 0, ext, comm, x;
  logic [7:0] pols [3] = '{SSP_POL_OPEN, SSP_POL_CLOSED, SSP_POL_MIXED};
  int n_errors = 0, checks_done = 0;

  always #10 pclk = ~pclk;

  ssp_field_model field (.pclk(pclk), .want(tw), .run_req(run), .const_req(cs), .terminal_in(terminal_in),
    .drive_running(drive_running), .drive_const_speed(drive_const_speed));
  ssp_shutoff_set_select dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .terminal_in(terminal_in), .drive_running(drive_running), .drive_const_speed(drive_const_speed),
    .output_enable(output_enable), .active_set(active_set), .active_two_set(active_two_set));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next setup never rewrites psel in this time step
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic err);
    apb(1'b0, a, 32'h0);
    chk("prdata", r, exp);
    chk("pslverr", e, err);
  endtask

  // Terminal levels need partner, two sync flops and the pending and active set registers
  task automatic settle(input logic [1:0] set, input logic two);
    repeat (8) @(posedge pclk);
    chk("active_set", active_set, set);
    chk("active_two_set", active_two_set, two);
  endtask

  task automatic en_is(input logic exp);
    repeat (8) @(posedge pclk);
    chk("output_enable", output_enable, exp);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    complete_run;
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(SSP_ADDR_POLARITY, 32'h0, 1'b0);
    rdc(SSP_ADDR_VALIDITY, 32'h0, 1'b0);
    rdc(SSP_ADDR_ASSIGN_BASE, 32'h18, 1'b0);
    rdc(SSP_ADDR_ASSIGN_BASE + 8'h04, 32'h3, 1'b0);
    rdc(SSP_ADDR_ASSIGN_BASE + 8'h08, 32'hff, 1'b0);
    rdc(8'h40, 32'h0, 1'b1);
    rdc(8'h01, 32'h0, 1'b1);
    wr(SSP_ADDR_STATUS, 32'hff);
    rdc(SSP_ADDR_STATUS, 32'h1, 1'b0);
    $display("test registers done");
    // Every row of the polarity table, terminal 0 as the shutoff input
    for (int i = 0; i < 3; i++) begin
      for (int k = 0; k < 4; k++) begin
        ext = k[1];
        comm = k[0];
        wr(SSP_ADDR_POLARITY, {24'h0, pols[i]});
        wr(SSP_ADDR_COMM, {31'h0, comm});
        tw <= {11'h0, ext};
        x = (i == 0) ? (!ext && !comm) : (i == 1) ? (ext && comm) : (ext && !comm);
        en_is(x);
      end
    end
    $display("test polarity done");
    wr(SSP_ADDR_POLARITY, 32'h4);
    wr(SSP_ADDR_COMM, 32'h2);
    tw <= 12'h001;
    en_is(1'b0);
    wr(SSP_ADDR_COMM, 32'h0);
    en_is(1'b1);
    wr(SSP_ADDR_POLARITY, 32'h2);
    wr(SSP_ADDR_COMM, 32'h3);
    en_is(1'b0);
    wr(SSP_ADDR_COMM, 32'h0);
    wr(SSP_ADDR_POLARITY, 32'h0);
    wr(SSP_ADDR_ASSIGN_BASE, 32'hff);
    wr(SSP_ADDR_ASSIGN_BASE + 8'h14, 32'h18);
    wr(SSP_ADDR_ASSIGN_BASE + 8'h18, 32'h18);
    tw <= 12'h021;
    en_is(1'b0);
    tw <= 12'h040;
    en_is(1'b0);
    tw <= 12'h001;
    en_is(1'b1);
    $display("test shutoff routing done");
    tw <= 12'h002;
    settle(SSP_SET_SECOND, 1'b1);
    wr(SSP_ADDR_ASSIGN_BASE + 8'h1c, 32'h9);
    tw <= 12'h082;
    settle(SSP_SET_THIRD, 1'b1);
    rdc(SSP_ADDR_STATUS, 32'h6d, 1'b0);
    run <= 1'b1;
    tw <= 12'h000;
    settle(SSP_SET_THIRD, 1'b1);
    run <= 1'b0;
    settle(SSP_SET_FIRST, 1'b0);
    wr(SSP_ADDR_VALIDITY, 32'ha);
    tw <= 12'h080;
    settle(SSP_SET_FIRST, 1'b0);
    run <= 1'b1;
    cs <= 1'b1;
    settle(SSP_SET_THIRD, 1'b0);
    cs <= 1'b0;
    settle(SSP_SET_FIRST, 1'b0);
    run <= 1'b0;
    $display("test set selection done");
    complete_run;
  end
endmodule
